/* hw/sfoc_device.sv */
// Flash end: command decode, hold, protection, busy and deep sleep control
module sfoc_device import sfoc_pkg::*; #(
    parameter int ADDR_W = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    sfoc_link_if.device link,
    output logic o_active,
    output logic o_deep_sleep,
    output logic o_busy,
    output logic [7:0] o_status
);
    typedef enum logic [3:0] {
        SFOC_ST_CMD = 4'b0001,
        SFOC_ST_ADDR = 4'b0010,
        SFOC_ST_DATA = 4'b0100,
        SFOC_ST_SKIP = 4'b1000
    } sfoc_dst_t;

    logic [1:0] cs_s, clk_s, hold_s, wp_s, d0_s, d1_s;
    logic clk_prev, cs_prev;
    logic seen_fall;
    logic [7:0] mem [0:(1<<ADDR_W)-1];
    sfoc_dst_t st;
    logic [7:0] cmd, sh, status, tx;
    logic [2:0] bitc;
    logic [1:0] abyte;
    logic [ADDR_W-1:0] addr;
    logic [15:0] busy_cnt;
    logic [1:0] wipe_kind;
    logic wipe_go;
    logic [ADDR_W-1:0] wipe_addr;
    logic [ADDR_W-1:0] wipe_idx;
    logic wiping;
    logic sleeping;
    logic out0, out1, dual_out;

    // Two-flop sampling of every pin
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cs_s <= 2'b11;
            clk_s <= 2'b00;
            hold_s <= 2'b11;
            wp_s <= 2'b11;
            d0_s <= 2'b00;
            d1_s <= 2'b00;
        end else begin
            cs_s <= {cs_s[0], link.chip_pick_n};
            clk_s <= {clk_s[0], link.bit_timing_in};
            hold_s <= {hold_s[0], link.hold_n};
            wp_s <= {wp_s[0], link.protect_pin};
            d0_s <= {d0_s[0], link.io_line0};
            d1_s <= {d1_s[0], link.io_line1};
        end
    end

    wire sel = ~cs_s[1];
    wire holding = sel & ~hold_s[1]; // see (RULE4) see (RULE6) see (RULE20)
    wire rise = clk_s[1] & ~clk_prev & sel & ~holding; // see (RULE5) see (RULE8)
    wire fall = ~clk_s[1] & clk_prev & sel & ~holding;
    wire two_in = (cmd == CMD_TWO_PIN_PAGE_WRITE) && (st == SFOC_ST_DATA);
    wire [7:0] nsh = two_in ? {sh[5:0], d1_s[1], d0_s[1]} : {sh[6:0], d0_s[1]}; // see (RULE19)
    wire byte_done = rise && (two_in ? bitc == 3'd6 : bitc == 3'd7);
    wire modify = status[STAT_UNLOCK_BIT] & ~sleeping & ~o_busy;

    function automatic logic is_wipe(input logic [7:0] c);
        return c == CMD_SMALL_BLOCK_WIPE || c == CMD_BLOCK64K_WIPE || c == CMD_WHOLE_ARRAY_WIPE;
    endfunction

    function automatic logic needs_addr(input logic [7:0] c);
        return c == CMD_PAGE_WRITE || c == CMD_TWO_PIN_PAGE_WRITE || c == CMD_READ ||
               c == CMD_TWO_PIN_FAST_READ || c == CMD_SMALL_BLOCK_WIPE ||
               c == CMD_BLOCK64K_WIPE;
    endfunction

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            clk_prev <= 1'b0;
            cs_prev <= 1'b1;
        end else begin
            clk_prev <= clk_s[1];
            cs_prev <= cs_s[1];
        end
    end

    // Decoding waits for the first select falling edge after reset
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            seen_fall <= 1'b0;
        end else if (cs_prev && !cs_s[1]) begin
            seen_fall <= 1'b1; // see (RULE3)
        end
    end

    // Serial shifting and command decode
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= SFOC_ST_CMD;
            cmd <= 8'h00;
            sh <= 8'h00;
            bitc <= 3'd0;
            abyte <= 2'd0;
            addr <= '0;
            status <= STAT_RESET;
            busy_cnt <= 16'h0000;
            sleeping <= 1'b0;
            wipe_go <= 1'b0;
            wipe_kind <= 2'd0;
        end else begin
            wipe_go <= 1'b0;
            if (busy_cnt != 16'h0000) begin
                busy_cnt <= busy_cnt - 16'h0001;
            end
            if (!sel) begin
                // End of frame: act on completed wipe, page write or status write
                if (!cs_prev && st == SFOC_ST_SKIP && bitc == 3'd0 && modify) begin
                    if (cmd == CMD_WHOLE_ARRAY_WIPE) begin
                        wipe_go <= 1'b1; // see (RULE14) see (RULE15) see (RULE18)
                        wipe_kind <= 2'd2;
                        busy_cnt <= 16'(ARRAY_WIPE_CYCLES);
                        status[STAT_UNLOCK_BIT] <= 1'b0;
                    end
                end
                if (!cs_prev && modify && bitc == 3'd0 && st == SFOC_ST_DATA) begin
                    if (cmd == CMD_PAGE_WRITE || cmd == CMD_TWO_PIN_PAGE_WRITE) begin
                        busy_cnt <= 16'(PROGRAM_CYCLES); // see (RULE10) see (RULE16)
                        status[STAT_UNLOCK_BIT] <= 1'b0;
                    end else if (cmd == CMD_STATUS_WRITE) begin
                        busy_cnt <= 16'(STATUS_WRITE_CYCLES);
                        status[STAT_UNLOCK_BIT] <= 1'b0;
                    end
                end
                if (!cs_prev && modify && bitc == 3'd0 && st == SFOC_ST_SKIP
                        && is_wipe(cmd) && cmd != CMD_WHOLE_ARRAY_WIPE) begin
                    wipe_go <= 1'b1;
                    wipe_kind <= (cmd == CMD_SMALL_BLOCK_WIPE) ? 2'd0 : 2'd1;
                    busy_cnt <= (cmd == CMD_SMALL_BLOCK_WIPE) ? 16'(SUB_WIPE_CYCLES)
                                                              : 16'(BLOCK_WIPE_CYCLES);
                    status[STAT_UNLOCK_BIT] <= 1'b0;
                end
                st <= SFOC_ST_CMD;
                bitc <= 3'd0;
                cmd <= 8'h00;
            end else if (rise && seen_fall) begin
                sh <= nsh;
                bitc <= bitc + (two_in ? 3'd2 : 3'd1);
                if (byte_done) begin
                    bitc <= 3'd0;
                    unique case (st)
                        SFOC_ST_CMD: begin
                            cmd <= nsh;
                            abyte <= 2'd0;
                            if (sleeping) begin
                                // Only the wake instruction is honoured
                                if (nsh == CMD_WAKE_FROM_SLEEP) begin
                                    sleeping <= 1'b0; // see (RULE17)
                                end
                                st <= SFOC_ST_SKIP;
                            end else if (nsh == CMD_DEEP_SLEEP && !o_busy) begin
                                sleeping <= 1'b1;
                                st <= SFOC_ST_SKIP;
                            end else if (nsh == CMD_WRITE_UNLOCK && !o_busy) begin
                                status[STAT_UNLOCK_BIT] <= 1'b1;
                                st <= SFOC_ST_SKIP;
                            end else if (nsh == CMD_WRITE_LOCK && !o_busy) begin
                                status[STAT_UNLOCK_BIT] <= 1'b0;
                                st <= SFOC_ST_SKIP;
                            end else if (needs_addr(nsh)) begin
                                st <= SFOC_ST_ADDR;
                            end else if (nsh == CMD_STATUS_WRITE || nsh == CMD_STATUS_READ) begin
                                st <= SFOC_ST_DATA;
                            end else begin
                                st <= SFOC_ST_SKIP;
                            end
                        end
                        SFOC_ST_ADDR: begin
                            addr <= ADDR_W'({addr, nsh});
                            abyte <= abyte + 2'd1;
                            if (abyte == 2'(ADDR_BYTES - 1)) begin
                                st <= is_wipe(cmd) ? SFOC_ST_SKIP : SFOC_ST_DATA;
                            end
                        end
                        SFOC_ST_DATA: begin
                            if (cmd == CMD_STATUS_WRITE && modify) begin
                                // Guard bits freeze while protect is low and enabled
                                if (!(wp_s[1] == 1'b0 && status[STAT_PROTECT_EN_BIT])) begin
                                    status[STAT_GUARD_MSB:STAT_GUARD_LSB] <=
                                        nsh[STAT_GUARD_MSB:STAT_GUARD_LSB]; // see (RULE7)
                                    status[STAT_PROTECT_EN_BIT] <= nsh[STAT_PROTECT_EN_BIT];
                                end
                            end
                            // Address wraps over the whole ADDR_W range, one page only when ADDR_W is 8
                            addr <= addr + ADDR_W'(1); // see (RULE11)
                        end
                        SFOC_ST_SKIP: begin
                        end
                    endcase
                end
            end
            status[STAT_BUSY_BIT] <= (busy_cnt > 16'h0001) || wiping; // see (RULE21)
        end
    end

    // Array writes: programming only clears bits, wipes fill with ones
    always_ff @(posedge i_clk) begin
        if (sel && byte_done && st == SFOC_ST_DATA && modify &&
                (cmd == CMD_PAGE_WRITE || cmd == CMD_TWO_PIN_PAGE_WRITE)) begin
            mem[addr] <= mem[addr] & nsh; // see (RULE11) see (RULE13)
        end else if (wiping) begin
            mem[wipe_idx] <= ERASED_BYTE;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wiping <= 1'b0;
            wipe_idx <= '0;
            wipe_addr <= '0;
        end else if (wipe_go) begin
            wiping <= 1'b1;
            wipe_idx <= (wipe_kind == 2'd2) ? '0 : addr;
            wipe_addr <= (wipe_kind == 2'd2) ? '1 : addr;
        end else if (wiping) begin
            wipe_idx <= wipe_idx + ADDR_W'(1);
            wiping <= wipe_idx != wipe_addr && wipe_kind == 2'd2;
        end
    end

    // Output shifting on the falling clock edge
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tx <= 8'h00;
            out0 <= 1'b0;
            out1 <= 1'b0;
            dual_out <= 1'b0;
        end else if (!sel) begin
            dual_out <= 1'b0;
        end else if (fall) begin
            if (st == SFOC_ST_DATA && bitc == 3'd0) begin
                tx <= (cmd == CMD_STATUS_READ) ? status : mem[addr];
                dual_out <= cmd == CMD_TWO_PIN_FAST_READ; // see (RULE19)
                out1 <= (cmd == CMD_STATUS_READ) ? status[7] : mem[addr][7];
                out0 <= mem[addr][6];
            end else if (dual_out) begin
                out1 <= tx[5 - 2*bitc[1:0]];
                out0 <= tx[4 - 2*bitc[1:0]];
            end else begin
                out1 <= tx[7 - bitc];
            end
        end
    end

    wire reading = sel && st == SFOC_ST_DATA && !holding && !sleeping &&
                   (cmd == CMD_READ || cmd == CMD_STATUS_READ || cmd == CMD_TWO_PIN_FAST_READ);
    assign link.io1_d_o = out1;
    assign link.io1_d_oe = reading && !two_in; // see (RULE1) see (RULE5)
    assign link.io0_d_o = out0;
    assign link.io0_d_oe = reading && dual_out;
    assign o_active = sel || o_busy; // see (RULE2)
    assign o_deep_sleep = sleeping;
    assign o_busy = status[STAT_BUSY_BIT];
    assign o_status = status;
endmodule

/* hw/sfoc_pkg.sv */
// Shared constants for the serial flash operation control link and its two ends
// Summary of operation
// (RULE1) Deselected device floats its data output
// (RULE2) Standby only after internal cycle finishes
// (RULE3) No decoding before first select falling edge
// (RULE4) Hold pauses transfer without deselecting
// (RULE5) Hold floats output, ignores input and clock
// (RULE6) Hold only honoured while selected
// (RULE7) Protect pin freezes guard level bits
// (RULE8) Modes 0 and 3: sample rise, drive fall
// (RULE9) Master parks clock per chosen polarity
// (RULE10) Unlock then four-byte page write starts program
// (RULE11) Page write: up to 256 bytes, clear only
// (RULE12) Master writes a page in one sequence
// (RULE13) Two-pin page write: 256 bytes, two lines
// (RULE14) Erases set FFh and start erase cycle
// (RULE15) Erase acts only after write unlock
// (RULE16) Status register holds busy flag
// (RULE17) Deep sleep until wake instruction
// (RULE18) Deep sleep ignores write, program, erase
// (RULE19) Two-pin modes turn data lines around; the master keeps driving io_line0 while selected
// (RULE20) Hold active low, resumes interrupted bit
// (RULE21) Busy flag high only during internal cycle
package sfoc_pkg;
    localparam logic [7:0] CMD_WRITE_UNLOCK = 8'h06;
    localparam logic [7:0] CMD_WRITE_LOCK = 8'h04;
    localparam logic [7:0] CMD_STATUS_READ = 8'h05;
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_PAGE_WRITE = 8'h02;
    localparam logic [7:0] CMD_TWO_PIN_PAGE_WRITE = 8'ha2;
    localparam logic [7:0] CMD_TWO_PIN_FAST_READ = 8'h3b;
    localparam logic [7:0] CMD_SMALL_BLOCK_WIPE = 8'h20;
    localparam logic [7:0] CMD_BLOCK64K_WIPE = 8'hd8;
    localparam logic [7:0] CMD_WHOLE_ARRAY_WIPE = 8'hc7;
    localparam logic [7:0] CMD_DEEP_SLEEP = 8'hb9;
    localparam logic [7:0] CMD_WAKE_FROM_SLEEP = 8'hab;
    localparam int PAGE_BYTES = 256;
    localparam int ADDR_BYTES = 3;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_UNLOCK_BIT = 1;
    localparam int STAT_GUARD_LSB = 2;
    localparam int STAT_GUARD_MSB = 4;
    localparam int STAT_PROTECT_EN_BIT = 7;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam int PROGRAM_CYCLES = 64;
    localparam int SUB_WIPE_CYCLES = 128;
    localparam int BLOCK_WIPE_CYCLES = 256;
    localparam int ARRAY_WIPE_CYCLES = 512;
    localparam int STATUS_WRITE_CYCLES = 32;
    // Half link period in system clocks; must cover both two-flop paths and the output flop
    localparam int CLK_DIV_HALF = 8;
    typedef enum logic [1:0] {
        SFOC_OP_READ = 2'd0,
        SFOC_OP_WRITE = 2'd1,
        SFOC_OP_STATUS = 2'd2,
        SFOC_OP_CMD = 2'd3
    } sfoc_op_t;
endpackage

/* hw/sfoc_link_if.sv */
// Serial link between the flash end and the master end
interface sfoc_link_if;
    logic chip_pick_n;
    logic bit_timing_in;
    logic hold_n;
    logic protect_pin;
    logic io0_m_o;
    logic io0_m_oe;
    logic io0_d_o;
    logic io0_d_oe;
    logic io1_m_o;
    logic io1_m_oe;
    logic io1_d_o;
    logic io1_d_oe;
    wire io_line0 = io0_m_oe ? io0_m_o : (io0_d_oe ? io0_d_o : 1'b1);
    wire io_line1 = io1_m_oe ? io1_m_o : (io1_d_oe ? io1_d_o : 1'b1);
    modport device (
        input chip_pick_n, bit_timing_in, hold_n, protect_pin, io_line0, io_line1,
        output io0_d_o, io0_d_oe, io1_d_o, io1_d_oe
    );
    modport master (
        output chip_pick_n, bit_timing_in, hold_n, protect_pin, io0_m_o, io0_m_oe,
        output io1_m_o, io1_m_oe,
        input io_line0, io_line1
    );
endinterface

/* hw/sfoc_master.sv */
// Master end: byte transfers with divided serial clock, mode 0 or 3
module sfoc_master import sfoc_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_cpol,
    input wire logic i_start,
    input wire logic i_last,
    input wire logic [7:0] i_tx,
    input wire logic i_hold,
    input wire logic i_protect,
    output logic o_ready,
    output logic o_done,
    output logic [7:0] o_rx,
    sfoc_link_if.master link
);
    typedef enum logic [2:0] {
        SFOC_M_IDLE = 3'b001,
        SFOC_M_SHIFT = 3'b010,
        SFOC_M_GAP = 3'b100
    } sfoc_mst_t;

    sfoc_mst_t st;
    logic [3:0] div;
    logic sck, cs_n;
    logic [3:0] bits;
    logic [7:0] sh, rx;
    logic last;
    logic [1:0] d1_s;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            d1_s <= 2'b00;
        end else begin
            d1_s <= {d1_s[0], link.io_line1};
        end
    end

    wire tick = div == 4'(CLK_DIV_HALF - 1);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= SFOC_M_IDLE;
            div <= 4'd0;
            sck <= 1'b0;
            cs_n <= 1'b1;
            bits <= 4'd0;
            sh <= 8'h00;
            rx <= 8'h00;
            last <= 1'b0;
            o_done <= 1'b0;
            o_rx <= 8'h00;
        end else begin
            o_done <= 1'b0;
            unique case (st)
                SFOC_M_IDLE: begin
                    // Park only between frames: a level change inside one is a false edge
                    if (cs_n) begin
                        sck <= i_cpol; // see (RULE9)
                    end
                    div <= 4'd0;
                    if (i_start) begin
                        cs_n <= 1'b0; // see (RULE3) see (RULE6)
                        sh <= i_tx;
                        last <= i_last;
                        bits <= 4'd0;
                        sck <= 1'b0;
                        st <= SFOC_M_SHIFT;
                    end
                end
                SFOC_M_SHIFT: begin
                    if (!i_hold) begin
                        div <= tick ? 4'd0 : div + 4'd1;
                        if (tick) begin
                            sck <= ~sck;
                            if (!sck) begin
                                rx <= {rx[6:0], d1_s[1]}; // see (RULE8)
                                bits <= bits + 4'd1;
                            end else begin
                                sh <= {sh[6:0], 1'b0};
                                if (bits == 4'd8) begin
                                    st <= SFOC_M_GAP;
                                end
                            end
                        end
                    end
                end
                SFOC_M_GAP: begin
                    o_done <= 1'b1;
                    o_rx <= rx;
                    sck <= last ? i_cpol : 1'b0;
                    cs_n <= last;
                    st <= SFOC_M_IDLE;
                end
            endcase
        end
    end

    assign o_ready = st == SFOC_M_IDLE;
    assign link.chip_pick_n = cs_n;
    assign link.bit_timing_in = sck;
    assign link.hold_n = ~(i_hold && !cs_n); // see (RULE4) see (RULE6)
    assign link.protect_pin = ~i_protect;
    assign link.io0_m_o = sh[7];
    assign link.io0_m_oe = !cs_n;
    assign link.io1_m_o = 1'b0;
    assign link.io1_m_oe = 1'b0;
endmodule

/* testbench/sfoc_properties.sv */
// Concurrent checks on the serial link between the master and device ends
module sfoc_properties (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic chip_pick_n,
    input wire logic bit_timing_in,
    input wire logic hold_n,
    input wire logic protect_pin,
    input wire logic io0_m_o,
    input wire logic io0_m_oe,
    input wire logic io0_d_o,
    input wire logic io0_d_oe,
    input wire logic io1_m_o,
    input wire logic io1_m_oe,
    input wire logic io1_d_o,
    input wire logic io1_d_oe
);
    logic seen_fall;
    logic idle_level;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // Set once the master has selected the device
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            seen_fall <= 1'b0;
        end else if (!chip_pick_n) begin
            seen_fall <= 1'b1;
        end
    end

    // Clock level seen just before a frame opens
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            idle_level <= 1'b0;
        end else if (chip_pick_n) begin
            idle_level <= bit_timing_in;
        end
    end

    // Allows for the device's two-flop pin synchroniser
    sequence s_deselected;
        chip_pick_n [*4];
    endsequence

    sequence s_held;
        (!hold_n && !chip_pick_n) [*4];
    endsequence

    deselect_float_a: assert property (s_deselected |-> !io1_d_oe && !io0_d_oe)
        else $error("device drives a data line while deselected");
    hold_float_a: assert property (s_held |-> !io1_d_oe)
        else $error("device drives io_line1 during hold");
    prestart_quiet_a: assert property (!seen_fall |-> !io1_d_oe && !io0_d_oe)
        else $error("device drives before the first select");
    dev_out_edge_a: assert property (
        io1_d_oe && $past(io1_d_oe) && $changed(io1_d_o) |-> !bit_timing_in)
        else $error("device output changed while clock high");
    mst_setup_a: assert property (
        $rose(bit_timing_in) && !chip_pick_n |-> $stable(io0_m_o) ##1 $stable(io0_m_o))
        else $error("master data moved at the sampling edge");
    idle_level_a: assert property ($rose(chip_pick_n) |-> bit_timing_in == idle_level)
        else $error("clock not back at idle level at frame end");
    io0_contention_a: assert property (!(io0_m_oe && io0_d_oe))
        else $error("both ends drive io_line0");
    io1_contention_a: assert property (!(io1_m_oe && io1_d_oe))
        else $error("both ends drive io_line1");
endmodule

/* testbench/serial_flash_op_control_tb.sv */
// Self-checking bench joining the master and device ends over the serial link
`define CHECK_EQ(name, exp, got) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("ERROR %s expected %h seen %h", name, exp, got); \
    end \
end

module serial_flash_op_control_tb import sfoc_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;

    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_cpol = 1'b0;
    logic i_start = 1'b0;
    logic i_last = 1'b0;
    logic [7:0] i_tx = 8'h00;
    logic i_hold = 1'b0;
    logic i_protect = 1'b0;
    logic o_ready, o_done, o_active, o_deep_sleep, o_busy;
    logic [7:0] o_rx, o_status, rx;
    int num_errors = 0;
    int check_count = 0;
    logic [7:0] wipes [3] = '{CMD_SMALL_BLOCK_WIPE, CMD_BLOCK64K_WIPE, CMD_WHOLE_ARRAY_WIPE};
    int wlen [3] = '{3, 3, 0};

    sfoc_link_if link ();

    sfoc_device sfoc_device_inst (.i_clk(i_clk), .i_rst(i_rst), .link(link),
        .o_active(o_active), .o_deep_sleep(o_deep_sleep), .o_busy(o_busy), .o_status(o_status));

    sfoc_master sfoc_master_inst (.i_clk(i_clk), .i_rst(i_rst), .i_cpol(i_cpol),
        .i_start(i_start), .i_last(i_last), .i_tx(i_tx), .i_hold(i_hold),
        .i_protect(i_protect), .o_ready(o_ready), .o_done(o_done), .o_rx(o_rx), .link(link));

    sfoc_properties sfoc_properties_inst (.i_clk(i_clk), .i_rst(i_rst),
        .chip_pick_n(link.chip_pick_n), .bit_timing_in(link.bit_timing_in),
        .hold_n(link.hold_n), .protect_pin(link.protect_pin),
        .io0_m_o(link.io0_m_o), .io0_m_oe(link.io0_m_oe), .io0_d_o(link.io0_d_o),
        .io0_d_oe(link.io0_d_oe), .io1_m_o(link.io1_m_o), .io1_m_oe(link.io1_m_oe),
        .io1_d_o(link.io1_d_o), .io1_d_oe(link.io1_d_oe));

    always #4 i_clk = ~i_clk;

    task automatic end_of_test();
        if (num_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One byte; with hd set, hold is raised part way through the byte
    task automatic xfer(input logic [7:0] tx, input logic last, input logic hd);
        int n;
        n = 0;
        while (o_ready !== 1'b1 && n < 200) begin
            @(negedge i_clk);
            n++;
        end
        i_tx = tx;
        i_last = last;
        i_start = 1'b1;
        @(negedge i_clk);
        i_start = 1'b0;
        if (hd) begin
            repeat (30) @(negedge i_clk);
            i_hold = 1'b1;
            repeat (40) @(negedge i_clk);
            i_hold = 1'b0;
        end
        n = 0;
        while (o_done !== 1'b1 && n < 400) begin
            @(negedge i_clk);
            n++;
        end
        if (n >= 400) begin
            num_errors++;
        end
        rx = o_rx;
        @(negedge i_clk);
    endtask

    // Instruction byte, then nb further bytes: 1 data, 3 address, or 3 address and 1 data
    task automatic txn(input logic [7:0] op, input int nb, input logic [23:0] adr,
                       input logic [7:0] dat, input logic hd = 1'b0);
        logic [7:0] b [5];
        b = '{op, adr[23:16], adr[15:8], adr[7:0], dat};
        if (nb == 1) begin
            b[1] = dat;
        end
        for (int i = 0; i <= nb; i++) begin
            xfer(b[i], i == nb, hd && i == nb);
        end
        repeat (4) @(negedge i_clk);
    endtask

    task automatic wr(input logic [7:0] op, input int nb, input logic [7:0] dat);
        txn(CMD_WRITE_UNLOCK, 0, 24'h0, 8'h00);
        txn(op, nb, 24'h000010, dat);
    endtask

    task automatic wait_idle(input int lim);
        int n;
        n = 0;
        while (o_busy !== 1'b0 && n < lim) begin
            @(negedge i_clk);
            n++;
        end
        `CHECK_EQ("busy cleared", 1'b0, o_busy)
    endtask

    initial begin
        for (int m = 0; m < 2; m++) begin
            i_cpol = m[0];
            i_rst = 1'b1;
            repeat (12) @(negedge i_clk);
            i_rst = 1'b0;
            @(negedge i_clk);
            `CHECK_EQ("status reset", STAT_RESET, o_status)
            txn(CMD_SMALL_BLOCK_WIPE, 3, 24'h000010, 8'h00);
            `CHECK_EQ("wipe without unlock", 1'b0, o_busy)
            foreach (wipes[k]) begin
                wr(CMD_PAGE_WRITE, 4, 8'h00);
                wait_idle(PROGRAM_CYCLES + 50);
                wr(wipes[k], wlen[k], 8'h00);
                `CHECK_EQ("wipe busy", 1'b1, o_busy)
                `CHECK_EQ("active while busy", 1'b1, o_active)
                if (wlen[k] == 0) begin
                    txn(CMD_STATUS_READ, 1, 24'h0, 8'h00);
                    `CHECK_EQ("busy polled", 1'b1, rx[STAT_BUSY_BIT])
                end
                wait_idle(ARRAY_WIPE_CYCLES + 50);
                `CHECK_EQ("standby", 1'b0, o_active)
                txn(CMD_READ, 4, 24'h000010, 8'h00);
                `CHECK_EQ("wiped byte", ERASED_BYTE, rx)
            end
            txn(CMD_WRITE_UNLOCK, 0, 24'h0, 8'h00);
            `CHECK_EQ("unlock bit", 1'b1, o_status[STAT_UNLOCK_BIT])
            txn(CMD_PAGE_WRITE, 4, 24'h000010, 8'h5a);
            `CHECK_EQ("program busy", 1'b1, o_busy)
            wait_idle(PROGRAM_CYCLES + 50);
            wr(CMD_PAGE_WRITE, 4, 8'hf0);
            wait_idle(PROGRAM_CYCLES + 50);
            txn(CMD_READ, 4, 24'h000010, 8'h00, 1'b1);
            `CHECK_EQ("read across hold", 8'h50, rx)
            txn(CMD_DEEP_SLEEP, 0, 24'h0, 8'h00);
            `CHECK_EQ("asleep", 1'b1, o_deep_sleep)
            wr(CMD_PAGE_WRITE, 4, 8'h00);
            `CHECK_EQ("sleep ignores program", 1'b0, o_busy)
            txn(CMD_WAKE_FROM_SLEEP, 0, 24'h0, 8'h00);
            `CHECK_EQ("awake", 1'b0, o_deep_sleep)
            txn(CMD_READ, 4, 24'h000010, 8'h00);
            `CHECK_EQ("byte kept", 8'h50, rx)
            wr(CMD_STATUS_WRITE, 1, 8'h84);
            wait_idle(STATUS_WRITE_CYCLES + 50);
            `CHECK_EQ("guard set", 3'b001, o_status[STAT_GUARD_MSB:STAT_GUARD_LSB])
            i_protect = 1'b1;
            wr(CMD_STATUS_WRITE, 1, 8'h98);
            wait_idle(STATUS_WRITE_CYCLES + 50);
            `CHECK_EQ("guard frozen", 3'b001, o_status[STAT_GUARD_MSB:STAT_GUARD_LSB])
            i_protect = 1'b0;
        end
        end_of_test();
    end

    // Roughly three times the expected length of both passes
    initial begin
        repeat (80000) @(posedge i_clk);
        num_errors++;
        end_of_test();
    end
endmodule
